/* File: dspal_host.sv */
// Purpose: host model for the serial port
// Assumes: link clock runs only inside frames
// Notes: released din rests at the pull-up level
`timescale 1ns/10ps
module dspal_host (
	output logic sclk = 0,
	output logic frame_n = 1,
	output logic din = 1
);
	task automatic xfer(input int n, input logic [15:0] d);
		frame_n = 0;
		for (int i = n - 1; i >= 0; i--) begin
			din = d[i];
			#16 sclk = 1;
			#16 sclk = 0;
		end
		#16 frame_n = 1;
		din = 1;
		#32;
	endtask : xfer
endmodule : dspal_host

/* File: dspal_map.svh */
// Purpose: constants for the dual serial port address latch
// Assumes: included by its bare name
// Notes: definitions only
`ifndef DSPAL_MAP_SVH
`define DSPAL_MAP_SVH
`define DSPAL_ADDR_LOW 7'h48
`define DSPAL_ADDR_FLOAT 7'h4A
`define DSPAL_ADDR_HIGH 7'h4B
`define DSPAL_ADDR_BITS 4'h8
`define DSPAL_SEEN_TWICE 2'h2
`define DSPAL_FRAME_BITS 5'h10
`define DSPAL_ALERT_POL_RST 1'h0
`define DSPAL_LOAD_BIT 5'h01
`define DSPAL_RD_IDLE 16'hffff
`endif

/* File: dspal_pkg.sv */
// Purpose: types for the dual serial port address latch
// Assumes: nothing
// Notes: none
package dspal_pkg;
	typedef enum logic [1:0] {
		DSPAL_SEL_LOW = 2'b00,
		DSPAL_SEL_FLOAT = 2'b01,
		DSPAL_SEL_HIGH = 2'b10
	} dspal_sel_t;
	typedef struct packed {
		logic [15:0] data;
		logic valid;
	} dspal_word_t;
	typedef enum logic [1:0] {
		DSPAL_I2C_IDLE = 2'b00,
		DSPAL_I2C_ADDR = 2'b01,
		DSPAL_I2C_SKIP = 2'b10
	} dspal_i2c_st_t;
endpackage : dspal_pkg

/* File: dspal_properties.sv */
// Purpose: port checker for dspal_top
// Assumes: clk domain only, rst synchronous
// Notes: bind at foot
`timescale 1ns/10ps
module dspal_properties import dspal_pkg::*; (
	input wire logic clk,
	input wire logic rst,
	input wire logic two_wire_mode,
	input wire logic alert_pol_high,
	input wire logic limit_exceeded,
	input wire dspal_pkg::dspal_sel_t addr_sel,
	input wire dspal_pkg::dspal_word_t wr_word,
	input wire logic dout_o,
	input wire logic dout_oe,
	input wire logic alert_o,
	input wire logic alert_oe,
	input wire logic [6:0] bus_addr,
	input wire logic addr_latched
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	localparam logic [6:0] MAP [3] = '{7'h48, 7'h4a, 7'h4b};
	AST_OD_DOUT: assert property (!dout_o) else $error("dout");
	AST_OD_ALERT: assert property (!alert_o) else $error("alert");
	AST_PIN_IN: assert property (two_wire_mode [*4] |-> !dout_oe)
		else $error("pin");
	AST_POL: assert property (($stable(limit_exceeded) &&
		$stable(alert_pol_high)) [*3] |->
		alert_oe == (limit_exceeded ^ alert_pol_high)) else $error("pol");
	AST_MAP: assert property ((!addr_latched && $stable(addr_sel)) [*3]
		|-> bus_addr == MAP[addr_sel]) else $error("map");
	AST_HOLD: assert property (addr_latched |=> addr_latched &&
		$stable(bus_addr)) else $error("hold");
	AST_RST: assert property ($fell(rst) && !limit_exceeded &&
		!alert_pol_high |-> !alert_oe && !addr_latched) else $error("rst");
	AST_PULSE: assert property (wr_word.valid |=> !wr_word.valid)
		else $error("valid");
	cover property ($rose(addr_latched));
	cover property (wr_word.valid);
	cover property (alert_oe && alert_pol_high);
endmodule : dspal_properties
bind dspal_top dspal_properties i_dspal_properties (.*);

/* File: dspal_top.sv */
// Purpose: serial port front end: framed mode shifter, two-wire address
//          latch, open-drain limit alert
// Assumes: serial clock is the link clock; sda/scl sampled in sclk domain
// Notes: address select level arrives as a decoded enum from the pad
`timescale 1ns/10ps
`include "dspal_map.svh"

// Function
// - frame select low opens a transfer and enables the input shifter.
// - sample data on rising clock edges, drive read data on falling.
// - alert asserts when any reading exceeds limit; polarity selectable.
// - alert polarity is active low after reset.
// - alert and serial data out only pull low or release.
// - select low, float, high give 1001000, 1001010, 1001011.
// - address fixed only after it has been sent twice.
// - select level latched on eighth clock of second valid transfer.
// - after latching, select pin changes are ignored.
module dspal_top (
	input wire logic clk,
	input wire logic rst,
	input wire logic sclk,
	input wire logic frame_n,
	input wire logic din,
	input wire logic two_wire_mode,
	input wire logic alert_pol_high,
	input wire logic limit_exceeded,
	input wire dspal_pkg::dspal_sel_t addr_sel,
	input wire dspal_pkg::dspal_word_t rd_word,
	output dspal_pkg::dspal_word_t wr_word,
	output logic dout_o,
	output logic dout_oe,
	output logic alert_o,
	output logic alert_oe,
	output logic [6:0] bus_addr,
	output logic addr_latched
);
	import dspal_pkg::*;

	// ------------------------------------------------------------
	// address decode
	// ------------------------------------------------------------
	function automatic logic [6:0] sel_to_addr(input dspal_sel_t s);
		if (s == DSPAL_SEL_LOW)
			sel_to_addr = `DSPAL_ADDR_LOW;
		else if (s == DSPAL_SEL_FLOAT)
			sel_to_addr = `DSPAL_ADDR_FLOAT;
		else
			sel_to_addr = `DSPAL_ADDR_HIGH;
	endfunction : sel_to_addr

	// ------------------------------------------------------------
	// link domain: framed shifter and two-wire address watcher
	// ------------------------------------------------------------
	// frame_n and din come in on the link clock itself, so no sync there
	logic [15:0] shin_q;
	logic [15:0] shout_q;
	logic [4:0] bitcnt_q;
	logic [15:0] word_q;
	logic word_tgl_q;
	logic dout_low_q;
	logic [3:0] acnt_q;
	logic [6:0] ashift_q;
	logic [1:0] seen_q;
	logic lat_q;
	logic [6:0] lat_addr_q;
	logic mode1_q;
	logic mode2_q;
	dspal_sel_t sel_l1_q;
	dspal_sel_t sel_l2_q;
	// the host stops the link clock between transfers, so frame select
	// itself has to clear the per-transfer state
	wire link_clr = rst | frame_n;
	wire framed = ~mode2_q & ~frame_n;
	wire tw_active = mode2_q & ~frame_n;
	wire frame_end = (bitcnt_q == `DSPAL_FRAME_BITS - 5'h01);
	wire [4:0] bitcnt_nx = frame_end ? 5'h00 : bitcnt_q + 5'h01;
	wire out_load = (bitcnt_q == `DSPAL_LOAD_BIT);
	// nothing to send: keep the line released
	wire [15:0] rd_bits = rd_word.valid ? rd_word.data : `DSPAL_RD_IDLE;
	wire [15:0] shout_nx = out_load ? {rd_bits[14:0], 1'b0} :
		{shout_q[14:0], 1'b0};
	wire [6:0] live_addr = sel_to_addr(sel_l2_q);
	wire [6:0] cmp_addr = lat_q ? lat_addr_q : live_addr;
	wire [6:0] rx_addr = {ashift_q[5:0], din};
	wire [3:0] acnt_nx = (acnt_q == `DSPAL_ADDR_BITS) ? acnt_q :
		acnt_q + 4'h1;
	// eighth rise: seven address bits are in, the direction bit is on din
	wire eighth = tw_active & (acnt_q == `DSPAL_ADDR_BITS - 4'h1);
	wire addr_hit = eighth & (ashift_q == cmp_addr);
	wire [1:0] seen_nx = seen_q + 2'h1;

	// mode and select pins are asynchronous to the link clock; a mode
	// change settles over the first two link clocks of a transfer
	always_ff @(posedge sclk or posedge rst) begin
		if (rst) begin
			mode1_q <= 1'b0;
			mode2_q <= 1'b0;
		end else begin
			mode1_q <= two_wire_mode;
			mode2_q <= mode1_q;
		end
	end

	always_ff @(posedge sclk) begin
		sel_l1_q <= addr_sel;
		sel_l2_q <= sel_l1_q;
	end

	always_ff @(posedge sclk or posedge link_clr) begin
		if (link_clr) begin
			bitcnt_q <= 5'h00;
			acnt_q <= 4'h0;
		end else begin
			bitcnt_q <= framed ? bitcnt_nx : 5'h00;
			acnt_q <= tw_active ? acnt_nx : 4'h0;
		end
	end

	always_ff @(posedge sclk or posedge rst) begin
		if (rst) begin
			shin_q <= 16'h0000;
			word_q <= 16'h0000;
			word_tgl_q <= 1'b0;
		end else if (framed) begin
			shin_q <= {shin_q[14:0], din};
			if (frame_end) begin
				word_q <= {shin_q[14:0], din};
				word_tgl_q <= ~word_tgl_q;
			end
		end
	end

	// read data leaves on falling edges of the clocks that follow
	always_ff @(negedge sclk or posedge link_clr) begin
		if (link_clr) begin
			shout_q <= 16'h0000;
			dout_low_q <= 1'b0;
		end else if (framed) begin
			shout_q <= shout_nx;
			dout_low_q <= out_load ? ~rd_bits[15] :
				~shout_q[15];
		end else begin
			dout_low_q <= 1'b0;
		end
	end

	// two-wire: frame_n reused as a transfer-active strobe from the pad
	always_ff @(posedge sclk or posedge rst) begin
		if (rst) begin
			ashift_q <= 7'h00;
			seen_q <= 2'h0;
			lat_q <= 1'b0;
			lat_addr_q <= 7'h00;
		end else if (tw_active) begin
			ashift_q <= rx_addr;
			if (addr_hit & ~lat_q) begin
				seen_q <= seen_nx;
				if (seen_nx == `DSPAL_SEEN_TWICE) begin
					lat_q <= 1'b1;
					lat_addr_q <= live_addr;
				end
			end
		end
	end

	// ------------------------------------------------------------
	// system domain: crossings and pin drivers
	// ------------------------------------------------------------
	logic tgl1_q, tgl2_q, tgl3_q;
	logic lat1_q, lat2_q;
	logic lim1_q, lim2_q;
	logic dlow1_q, dlow2_q;
	logic mode_c1_q, mode_c2_q;
	logic pol1_q;
	logic pol_q;
	dspal_sel_t sel_c1_q;
	dspal_sel_t sel_c2_q;
	wire alert_low = pol_q ? 1'b0 : lim2_q;
	wire word_new = tgl2_q ^ tgl3_q;

	always_ff @(posedge clk) begin
		tgl1_q <= word_tgl_q;
		tgl2_q <= tgl1_q;
		lat1_q <= lat_q;
		lat2_q <= lat1_q;
		lim1_q <= limit_exceeded;
		lim2_q <= lim1_q;
		dlow1_q <= dout_low_q;
		dlow2_q <= dlow1_q;
		mode_c1_q <= two_wire_mode;
		mode_c2_q <= mode_c1_q;
		pol1_q <= alert_pol_high;
		sel_c1_q <= addr_sel;
		sel_c2_q <= sel_c1_q;
		if (rst) begin
			tgl3_q <= 1'b0;
			pol_q <= `DSPAL_ALERT_POL_RST;
			wr_word <= '0;
			dout_o <= 1'b0;
			dout_oe <= 1'b0;
			alert_o <= 1'b0;
			alert_oe <= 1'b0;
			bus_addr <= `DSPAL_ADDR_LOW;
			addr_latched <= 1'b0;
		end else begin
			tgl3_q <= tgl2_q;
			pol_q <= pol1_q;
			// word is stable for a whole frame after the toggle
			wr_word.valid <= word_new;
			if (word_new)
				wr_word.data <= word_q;
			dout_o <= 1'b0;
			dout_oe <= dlow2_q & ~mode_c2_q;
			alert_o <= 1'b0;
			// active high polarity: pull low while no limit is exceeded
			alert_oe <= pol_q ? ~lim2_q : alert_low;
			addr_latched <= lat2_q;
			// the latched address is written once, before its flag crosses
			bus_addr <= lat2_q ? lat_addr_q : sel_to_addr(sel_c2_q);
		end
	end
endmodule : dspal_top

/* File: dspal_top_test.sv */
// Purpose: bench for dspal_top
// Assumes: host model owns the link clock
// Notes: waits sized from the stated latencies
`timescale 1ns/10ps
module dspal_top_test;
	import dspal_pkg::*;
	logic clk = 0, rst = 1, two_wire_mode = 0, alert_pol_high = 0;
	logic limit_exceeded = 0, sclk, frame_n, din, dout_o, dout_oe;
	logic alert_o, alert_oe, addr_latched;
	logic [6:0] bus_addr;
	dspal_sel_t addr_sel = DSPAL_SEL_LOW;
	dspal_word_t rd_word = '{16'h5a5a, 1'h1}, wr_word;
	int fail_count = 0, n_checks = 0, n_words = 0;
	dspal_host i_dspal_host (.sclk(sclk), .frame_n(frame_n), .din(din));
	dspal_top i_dspal_top (
		.clk(clk),
		.rst(rst),
		.sclk(sclk),
		.frame_n(frame_n),
		.din(din),
		.two_wire_mode(two_wire_mode),
		.alert_pol_high(alert_pol_high),
		.limit_exceeded(limit_exceeded),
		.addr_sel(addr_sel),
		.rd_word(rd_word),
		.wr_word(wr_word),
		.dout_o(dout_o),
		.dout_oe(dout_oe),
		.alert_o(alert_o),
		.alert_oe(alert_oe),
		.bus_addr(bus_addr),
		.addr_latched(addr_latched)
	);
	initial forever #2.5 clk = ~clk;
	always @(negedge clk) n_words += (wr_word.valid === 1'h1);
	task automatic chk(input string s, input logic [15:0] e, g);
		n_checks++;
		if (g !== e) begin
			fail_count++;
			$display("MISMATCH %s exp %h got %h", s, e, g);
		end
	endtask : chk
	task automatic t_alert;
		for (int i = 0; i < 4; i++) begin
			{alert_pol_high, limit_exceeded} = 2'(i);
			repeat (4) @(negedge clk);
			chk("alert_oe", 16'(i[0] ^ i[1]), 16'(alert_oe));
		end
	endtask : t_alert
	task automatic t_frame;
		fork
			i_dspal_host.xfer(16, 16'ha5c3);
			begin
				repeat (11) @(negedge clk);
				chk("dout_oe_b15", 16'h1, 16'(dout_oe));
				repeat (6) @(negedge clk);
				chk("dout_oe_b14", 16'h0, 16'(dout_oe));
			end
		join
		i_dspal_host.xfer(16, 16'h3c5a);
		repeat (8) @(negedge clk);
		chk("dout_rel", 16'h0, 16'(dout_oe));
		chk("wr_data", 16'h3c5a, wr_word.data);
		chk("words", 16'h2, 16'(n_words));
	endtask : t_frame
	task automatic t_addr;
		two_wire_mode = 1;
		for (int i = 0; i < 3; i++) begin
			addr_sel = dspal_sel_t'(i);
			repeat (6) @(negedge clk);
			chk("decode", 16'({4'h9, 1'h0, i[0] | i[1], i[1]}), 16'(bus_addr));
		end
		i_dspal_host.xfer(8, 16'h0090);
		i_dspal_host.xfer(8, 16'h0096);
		repeat (10) @(negedge clk);
		chk("early", 16'h0, 16'(addr_latched));
		i_dspal_host.xfer(8, 16'h0096);
		repeat (10) @(negedge clk);
		chk("latched", 16'h1, 16'(addr_latched));
		addr_sel = DSPAL_SEL_LOW;
		repeat (6) @(negedge clk);
		chk("held", 16'h004b, 16'(bus_addr));
		chk("no_frame", 16'h2, 16'(n_words));
	endtask : t_addr
	task automatic wrap_up;
		if (fail_count == 0 && n_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : wrap_up
	initial begin
		repeat (6) @(negedge clk);
		rst = 0;
		t_alert;
		t_frame;
		t_addr;
		wrap_up;
	end
	initial begin
		#20000;
		fail_count++;
		wrap_up;
	end
endmodule : dspal_top_test
